// >>> srt_chr_if.sv
// Character hand-off between the line builder and the serialiser.
// Assumes both ends share aclk.
`timescale 1ns/1ps
`default_nettype none
interface srt_chr_if;
	logic [6:0] chr;
	logic valid;
	logic ready;
	logic [19:0] bit_cyc;
	modport src(output chr, output valid, output bit_cyc, input ready);
	modport snk(input chr, input valid, input bit_cyc, output ready);
endinterface
`default_nettype wire

// >>> srt_host_model.sv
// Far-side model: a host or printer on the current loop.
// Assumes the bench sets bit_cyc to the rate chosen in the block.
`timescale 1ns/1ps
`default_nettype none
module srt_host_model (
	input wire logic aclk,
	input wire logic ser,
	input wire logic hold,
	input wire logic [19:0] bit_cyc,
	output logic loop_mark
);
	logic [6:0] rx_q[$];
	time t_q[$];
	int frame_err = 0;
	logic [7:0] sh = 8'h00;
	time t0 = 0;

	// Loop current is cut only while the bench asks for hold-off
	assign loop_mark = ~hold;

	// Frame receiver sampling at bit centres
	// Seven data bits and parity, then the stop bit at its centre
	always begin
		@(negedge ser);
		t0 = $time;
		repeat (bit_cyc / 2) @(posedge aclk);
		if (ser !== 1'h0) begin
			frame_err++;
		end
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc) @(posedge aclk);
			sh[i] = ser;
		end
		repeat (bit_cyc) @(posedge aclk);
		if (ser !== 1'h1 || ^sh !== 1'h1) begin
			frame_err++;
		end
		rx_q.push_back(sh[6:0]);
		t_q.push_back(t0);
	end
endmodule
`default_nettype wire

// >>> srt_pkg.sv
// Shared constants for the serial response transmitter.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package srt_pkg;

	// Clock rate and documented times
	localparam int CLK_KHZ = 125000;
	localparam int DLY_MIN_MS = 400;
	localparam int PANEL_MAX_MS = 2000;
	localparam int PRT_HOLD_MS = 20;
	localparam int PRT_RPT_MS = 800;
	localparam int BAUD_TOP = 9600;
	localparam int DLY_CYC = DLY_MIN_MS * CLK_KHZ;
	localparam int PANEL_CYC = PANEL_MAX_MS * CLK_KHZ;
	localparam int PRT_CYC = PRT_HOLD_MS * CLK_KHZ;
	localparam int RPT_CYC = PRT_RPT_MS * CLK_KHZ;
	localparam int BIT_CYC_TOP = (CLK_KHZ * 1000) / BAUD_TOP;

	// Counter widths
	localparam int CW = 28;
	localparam int BW = 20;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_VALUE = 8'h08;
	localparam logic [7:0] OFS_MNEM = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;

	// Field positions and reset values
	localparam int CTRL_FULL = 0;
	localparam int CTRL_BAUD = 1;
	localparam int CTRL_EN1 = 4;
	localparam int CTRL_END = 6;
	localparam int CMD_GO = 4;
	localparam int VAL_NEG = 24;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] ADDR_MAX = 7'h63;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Line ending kinds
	localparam logic [1:0] END_NONE = 2'h0;
	localparam logic [1:0] END_CR = 2'h1;
	localparam logic [1:0] END_MID = 2'h2;
	localparam logic [1:0] END_BLK = 2'h3;

	// Character positions within a reply line
	localparam logic [4:0] POS_SKIP = 5'h08;
	localparam logic [4:0] POS_SIGN = 5'h08;
	localparam logic [4:0] POS_CR = 5'h0F;
	localparam logic [4:0] POS_LF = 5'h10;
	localparam logic [4:0] POS_XCR = 5'h11;
	localparam logic [4:0] POS_XLF = 5'h13;

	// ASCII codes
	localparam logic [6:0] CH_SP = 7'h20;
	localparam logic [6:0] CH_CR = 7'h0D;
	localparam logic [6:0] CH_LF = 7'h0A;
	localparam logic [6:0] CH_MINUS = 7'h2D;
	localparam logic [2:0] CH_DIGIT = 3'h3;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DELAY = 4'h2,
		ST_PUT = 4'h4,
		ST_DRAIN = 4'h8
	} srt_state_t;

endpackage

// >>> srt_ser_tx.sv
// Serialiser: one start, seven data, odd parity, one stop bit.
// Assumes bit_cyc holds steady while a character is on the line.
`timescale 1ns/1ps
`default_nettype none
module srt_ser_tx
	import srt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	srt_chr_if.snk ch,
	output logic ser_out
);
	logic act_r;
	logic [8:0] sh_r;
	logic [3:0] bitn_r;
	logic [BW-1:0] cnt_r;
	logic bit_end_w;
	logic take_w;

	// Bit timing and acceptance
	assign ch.ready = ~act_r;
	assign take_w = ch.valid & ~act_r;
	assign bit_end_w = act_r & (cnt_r == ch.bit_cyc - 20'h00001);

	// Shift out LSB first, mark when idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_r <= 1'b0;
			sh_r <= 9'h1FF;
			bitn_r <= 4'h0;
			cnt_r <= '0;
			ser_out <= 1'b1;
		end else if (take_w) begin
			act_r <= 1'b1;
			sh_r <= {1'b1, ~^ch.chr, ch.chr};
			bitn_r <= 4'h0;
			cnt_r <= '0;
			ser_out <= 1'b0;
		end else if (bit_end_w) begin
			cnt_r <= '0;
			if (bitn_r == 4'h9) begin
				act_r <= 1'b0;
			end else begin
				ser_out <= sh_r[0];
				sh_r <= {1'b1, sh_r[8:1]};
				bitn_r <= bitn_r + 4'h1;
			end
		end else if (act_r) begin
			cnt_r <= cnt_r + 20'h00001;
		end
	end

	property p_start_bit;
		@(posedge aclk) disable iff (!aresetn)
		take_w |=> !ser_out && act_r;
	endproperty
	a_start_bit: assert property (p_start_bit)
		else $error("start bit not low");

	property p_stop_bit;
		@(posedge aclk) disable iff (!aresetn)
		(act_r && bitn_r == 4'h9) |-> ser_out;
	endproperty
	a_stop_bit: assert property (p_stop_bit)
		else $error("stop bit not high");

endmodule
`default_nettype wire

// >>> srt_top.sv
// Reply line builder with AXI4-Lite registers and print inputs.
// Assumes loop and user inputs are synchronous to aclk.
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - A command write starts a reply line.
// - A low user input enabled for print starts a reply.
// - Abbreviated mode sends at once, no delay.
// - Full mode waits at least 400 ms before sending.
// - Full mode may wait up to 2 s while the panel is busy.
// - Full line opens with two address digits, blanks if zero, two spaces.
// - Then a three-letter value name and one space.
// - Value is zero padded; a minus sits just before the digits, after the space.
// - Each line ends with carriage return then line feed.
// - Single-line replies add one carriage return.
// - Last block line adds space, carriage return, line feed.
// - Command replies and middle block lines add nothing.
// - Abbreviated mode drops the first eight characters.
// - Characters start only while receive loop current flows.
// - Holding the print input past 800 ms gives a second print.
// - Print inputs act only while the receive loop is in mark.
// - Frame is start, seven data, odd parity, stop.
// - Bit rate selectable from 300 to 9600 baud.
// - Open receive loop pauses output between characters.
// - Unit address 0 to 99 appears in the address field.
module srt_top
	import srt_pkg::*;
#(
	parameter int unsigned DLY_N = DLY_CYC,
	parameter int unsigned PANEL_N = PANEL_CYC,
	parameter int unsigned PRT_N = PRT_CYC,
	parameter int unsigned RPT_N = RPT_CYC,
	parameter int unsigned BIT_N = BIT_CYC_TOP
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic loop_rx_mark,
	input wire logic panel_busy,
	input wire logic user_input_one_n,
	input wire logic user_input_two_n,
	output logic loop_tx_out
);
	srt_chr_if ch();
	srt_state_t st_r;
	logic [7:0] ctrl_r;
	logic [6:0] unit_addr_r;
	logic [24:0] value_r;
	logic [23:0] mnem_r;
	logic drop_r;
	logic [7:0] awaddr_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic [4:0] idx_r;
	logic [1:0] end_r;
	logic [CW-1:0] dly_r;
	logic valid_r;
	logic [6:0] chr_r;
	logic [CW-1:0] hold_r [2];
	logic [1:0] fire_w;
	logic [1:0] in_low_w;
	logic do_wr_w;
	logic wr_ok_w;
	logic rd_ok_w;
	logic [31:0] wm_w;
	logic [31:0] rd_w;
	logic cmd_go_w;
	logic trig_w;
	logic full_w;
	logic [1:0] trig_end_w;
	logic [3:0] tens_w;
	logic [3:0] ones_w;
	logic [6:0] ad_hi_w;
	logic [6:0] ad_lo_w;
	logic [139:0] line_w;
	logic [6:0] cur_w;
	logic skip_w;
	logic [4:0] last_w;
	logic dly_done_w;
	logic [2:0] baud_w;
	logic [4:0] bsh_w;

	// Write decode and byte-lane merge
	assign do_wr_w = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wm_w = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
	assign wr_ok_w = (awaddr_r == OFS_CTRL) | (awaddr_r == OFS_ADDR) |
		(awaddr_r == OFS_VALUE) | (awaddr_r == OFS_MNEM) |
		(awaddr_r == OFS_CMD) | (awaddr_r == OFS_STAT);
	assign rd_ok_w = (s_axi_araddr == OFS_CTRL) |
		(s_axi_araddr == OFS_ADDR) | (s_axi_araddr == OFS_VALUE) |
		(s_axi_araddr == OFS_MNEM) | (s_axi_araddr == OFS_CMD) |
		(s_axi_araddr == OFS_STAT);
	assign cmd_go_w = do_wr_w & (awaddr_r == OFS_CMD) & ws_r[0] &
		wd_r[CMD_GO];

	// Read data mux, status shows the block's own state
	assign rd_w = (s_axi_araddr == OFS_CTRL) ? {24'h000000, ctrl_r} :
		(s_axi_araddr == OFS_ADDR) ? {25'h0000000, unit_addr_r} :
		(s_axi_araddr == OFS_VALUE) ? {7'h00, value_r} :
		(s_axi_araddr == OFS_MNEM) ? {8'h00, mnem_r} :
		(s_axi_araddr == OFS_STAT) ?
		{29'h00000000, drop_r, (st_r == ST_PUT) & ~loop_rx_mark,
		st_r != ST_IDLE} : 32'h00000000;

	// Write address and data, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awaddr_r <= 8'h00;
			wd_r <= 32'h00000000;
			ws_r <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (do_wr_w) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read channel, one word per request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_w;
			s_axi_rresp <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RST;
			unit_addr_r <= 7'h00;
			value_r <= 25'h0000000;
			mnem_r <= 24'h000000;
		end else if (do_wr_w) begin
			if (awaddr_r == OFS_CTRL)
				ctrl_r <= 8'((32'(ctrl_r) & ~wm_w) | (wd_r & wm_w));
			if (awaddr_r == OFS_ADDR && ws_r[0] && wd_r[6:0] <= ADDR_MAX)
				unit_addr_r <= wd_r[6:0];
			if (awaddr_r == OFS_VALUE)
				value_r <= 25'((32'(value_r) & ~wm_w) | (wd_r & wm_w));
			if (awaddr_r == OFS_MNEM)
				mnem_r <= 24'((32'(mnem_r) & ~wm_w) | (wd_r & wm_w));
		end
	end

	// Dropped-trigger flag; a new drop wins over a clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			drop_r <= 1'b0;
		else if (trig_w && st_r != ST_IDLE)
			drop_r <= 1'b1;
		else if (do_wr_w && awaddr_r == OFS_STAT && ws_r[0] && wd_r[2])
			drop_r <= 1'b0;
	end

	// Print-request input hold timers, one per input
	assign in_low_w = {~user_input_two_n, ~user_input_one_n};
	generate
		for (genvar i = 0; i < 2; i++) begin : g_in
			assign fire_w[i] = in_low_w[i] & ctrl_r[CTRL_EN1+i] &
				loop_rx_mark &
				((hold_r[i] == CW'(PRT_N - 1)) |
				(hold_r[i] == CW'(RPT_N - 1)));
			always_ff @(posedge aclk) begin
				if (!aresetn)
					hold_r[i] <= '0;
				else if (!in_low_w[i])
					hold_r[i] <= '0;
				else if (hold_r[i] == CW'(RPT_N - 1))
					hold_r[i] <= CW'(PRT_N);
				else
					hold_r[i] <= hold_r[i] + CW'(1);
			end
		end
	endgenerate

	// Trigger sources and line ending chosen for them
	assign trig_w = cmd_go_w | (|fire_w);
	assign trig_end_w = cmd_go_w ? wd_r[1:0] : ctrl_r[CTRL_END+:2];
	assign full_w = ctrl_r[CTRL_FULL];
	assign dly_done_w = (dly_r >= CW'(DLY_N - 1) && !panel_busy) ||
		dly_r >= CW'(PANEL_N - 1);

	// Reply line characters, position 0 in the low bits
	assign tens_w = 4'(unit_addr_r / 7'h0A);
	assign ones_w = 4'(unit_addr_r % 7'h0A);
	assign ad_hi_w = (unit_addr_r == 7'h00) ? CH_SP : {CH_DIGIT, tens_w};
	assign ad_lo_w = (unit_addr_r == 7'h00) ? CH_SP : {CH_DIGIT, ones_w};
	assign line_w = {
		CH_LF, CH_CR, (end_r == END_BLK) ? CH_SP : CH_CR,
		CH_LF, CH_CR,
		{CH_DIGIT, value_r[3:0]}, {CH_DIGIT, value_r[7:4]},
		{CH_DIGIT, value_r[11:8]}, {CH_DIGIT, value_r[15:12]},
		{CH_DIGIT, value_r[19:16]}, {CH_DIGIT, value_r[23:20]},
		CH_MINUS,
		CH_SP, mnem_r[22:16], mnem_r[14:8], mnem_r[6:0],
		CH_SP, CH_SP, ad_lo_w, ad_hi_w};
	assign cur_w = line_w[7*idx_r+:7];
	assign skip_w = (~full_w & (idx_r < POS_SKIP)) |
		((idx_r == POS_SIGN) & ~value_r[VAL_NEG]);
	assign last_w = (end_r == END_CR) ? POS_XCR :
		(end_r == END_BLK) ? POS_XLF : POS_LF;

	// Reply sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_IDLE;
			idx_r <= 5'h00;
			end_r <= END_NONE;
			dly_r <= '0;
			valid_r <= 1'b0;
			chr_r <= CH_SP;
		end else begin
			valid_r <= 1'b0;
			unique case (st_r)
				ST_IDLE: begin
					idx_r <= 5'h00;
					dly_r <= '0;
					if (trig_w) begin
						end_r <= trig_end_w;
						st_r <= full_w ? ST_DELAY : ST_PUT;
					end
				end
				ST_DELAY: begin
					dly_r <= dly_r + CW'(1);
					if (dly_done_w)
						st_r <= ST_PUT;
				end
				ST_PUT: begin
					if (skip_w) begin
						idx_r <= idx_r + 5'h01;
					end else if (loop_rx_mark && ch.ready) begin
						valid_r <= 1'b1;
						chr_r <= cur_w;
						st_r <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (!valid_r && ch.ready) begin
						if (idx_r == last_w) begin
							st_r <= ST_IDLE;
						end else begin
							idx_r <= idx_r + 5'h01;
							st_r <= ST_PUT;
						end
					end
				end
			endcase
		end
	end

	// Serialiser hookup and bit rate selection
	assign baud_w = (ctrl_r[CTRL_BAUD+:3] > 3'h5) ? 3'h5 :
		ctrl_r[CTRL_BAUD+:3];
	assign bsh_w = 5'(3'h5 - baud_w);
	assign ch.bit_cyc = BW'(BIT_N) << bsh_w;
	assign ch.chr = chr_r;
	assign ch.valid = valid_r;

	srt_ser_tx u_ser (
		.aclk(aclk),
		.aresetn(aresetn),
		.ch(ch.snk),
		.ser_out(loop_tx_out)
	);

	property p_abbr_now;
		@(posedge aclk) disable iff (!aresetn)
		(st_r == ST_IDLE && trig_w && !full_w) |=> st_r == ST_PUT;
	endproperty
	a_abbr_now: assert property (p_abbr_now)
		else $error("abbreviated reply delayed");

	property p_full_wait;
		@(posedge aclk) disable iff (!aresetn)
		(st_r == ST_PUT && $past(st_r) == ST_DELAY) |->
			$past(dly_r) >= CW'(DLY_N - 1) &&
			$past(dly_r) <= CW'(PANEL_N - 1);
	endproperty
	a_full_wait: assert property (p_full_wait)
		else $error("full-mode delay out of range");

	property p_loop_gate;
		@(posedge aclk) disable iff (!aresetn)
		valid_r |-> $past(loop_rx_mark) && $past(st_r) == ST_PUT;
	endproperty
	a_loop_gate: assert property (p_loop_gate)
		else $error("character sent with loop open");

	property p_abbr_skip;
		@(posedge aclk) disable iff (!aresetn)
		(valid_r && !full_w) |-> idx_r >= POS_SKIP;
	endproperty
	a_abbr_skip: assert property (p_abbr_skip)
		else $error("header sent in abbreviated mode");

	property p_eol;
		@(posedge aclk) disable iff (!aresetn)
		(valid_r && (idx_r == POS_CR || idx_r == POS_LF)) |->
			chr_r == ((idx_r == POS_CR) ? CH_CR : CH_LF) &&
			last_w >= POS_LF;
	endproperty
	a_eol: assert property (p_eol)
		else $error("line feed does not follow return");

	property p_drop;
		@(posedge aclk) disable iff (!aresetn)
		(st_r != ST_IDLE && trig_w) |=> drop_r && $stable(end_r);
	endproperty
	a_drop: assert property (p_drop)
		else $error("trigger during reply not dropped");

	property p_line_end;
		@(posedge aclk) disable iff (!aresetn)
		(st_r == ST_IDLE && $past(st_r) == ST_DRAIN) |->
			$past(idx_r) == $past(last_w);
	endproperty
	a_line_end: assert property (p_line_end)
		else $error("line ended at wrong character");

	property p_open_loop;
		@(posedge aclk) disable iff (!aresetn)
		(st_r == ST_IDLE && !loop_rx_mark && !cmd_go_w) |=>
			st_r == ST_IDLE;
	endproperty
	a_open_loop: assert property (p_open_loop)
		else $error("print request taken with loop open");

endmodule
`default_nettype wire

// >>> test_serial_response_transmitter.sv
// Self-checking bench for the serial response transmitter.
// Assumes srt_host_model on the loop and shortened delay counts.
`timescale 1ns/1ps
`default_nettype none
module test_serial_response_transmitter
	import srt_pkg::*;
;
	localparam int DLY = 200;
	localparam int PAN = 600;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, mark, tx;
	logic [1:0] bresp, rresp;
	logic hold = 1'h0, panel = 1'h0, in1_n = 1'h1, in2_n = 1'h1;
	logic [19:0] bit_len = 20'h00004;
	int errors = 0;
	int n_tests = 0;
	logic [6:0] exp_q[$];
	logic [6:0] mnem[3] = '{7'h52, 7'h41, 7'h54};
	time t_cmd = 0;

	// Clock
	always #4 aclk = ~aclk;

	srt_top #(.DLY_N(DLY), .PANEL_N(PAN), .PRT_N(20), .RPT_N(100),
		.BIT_N(4)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.loop_rx_mark(mark), .panel_busy(panel),
		.user_input_one_n(in1_n), .user_input_two_n(in2_n),
		.loop_tx_out(tx));

	srt_host_model u_host (.aclk(aclk), .ser(tx), .hold(hold),
		.bit_cyc(bit_len), .loop_mark(mark));

	// Verdict and end of run
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic hang();
		errors++;
		$display("ERROR %0t: wait ran out", $time);
		final_report();
	endtask

	// Compare helpers, one per kind of result
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_chr(input logic [6:0] got, input logic [6:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: char %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_ok(input bit ok);
		n_tests++;
		if (!ok) begin
			errors++;
			$display("ERROR %0t: reply start time out of range", $time);
		end
	endtask

	// Register write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int k;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
			if (bvalid === 1'h1) break;
		end
		bready <= 1'h0;
		if (k == 50) hang();
		chk32({30'h0, bresp}, {30'h0, er});
		t_cmd = $time;
	endtask

	// Register read
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arready === 1'h1) arvalid <= 1'h0;
			if (rvalid === 1'h1) break;
		end
		rready <= 1'h0;
		if (k == 50) hang();
		chk32(rdata, ed);
		chk32({30'h0, rresp}, {30'h0, er});
	endtask

	// Expected reply line
	task automatic build(input bit full, input logic [6:0] ad,
		input logic [24:0] v, input logic [1:0] en);
		exp_q = {};
		if (full) begin
			if (ad == 7'h00) exp_q = {CH_SP, CH_SP};
			else exp_q = {7'h30 + ad / 7'h0A, 7'h30 + ad % 7'h0A};
			exp_q = {exp_q, CH_SP, CH_SP, mnem[0], mnem[1], mnem[2], CH_SP};
		end
		if (v[24]) exp_q.push_back(CH_MINUS);
		for (int i = 5; i >= 0; i--) exp_q.push_back({CH_DIGIT, v[i*4 +: 4]});
		exp_q = {exp_q, CH_CR, CH_LF};
		if (en == END_CR) exp_q.push_back(CH_CR);
		if (en == END_BLK) exp_q = {exp_q, CH_SP, CH_CR, CH_LF};
	endtask

	// Waits for the line, checks it and its start time (hi 0 skips)
	task automatic expect_line(input int lo, input int hi);
		int k;
		for (k = 0; k < 3000 + 300 * bit_len; k++) begin
			if (u_host.rx_q.size() >= exp_q.size()) break;
			@(posedge aclk);
		end
		if (k == 3000 + 300 * bit_len) hang();
		repeat (40 * bit_len) @(posedge aclk);
		chk32(u_host.rx_q.size(), exp_q.size());
		foreach (exp_q[i]) chk_chr(u_host.rx_q[i], exp_q[i]);
		if (hi > 0) begin
			chk_ok(u_host.t_q[0] >= t_cmd + lo * 8 &&
				u_host.t_q[0] <= t_cmd + hi * 8);
		end
		u_host.rx_q = {};
		u_host.t_q = {};
	endtask

	// Print request pulse on one input
	task automatic press(input bit two, input int len);
		@(posedge aclk);
		if (two) in2_n <= 1'h0;
		else in1_n <= 1'h0;
		t_cmd = $time;
		repeat (len) @(posedge aclk);
		in1_n <= 1'h1;
		in2_n <= 1'h1;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		for (int a = 0; a < 7; a++) begin
			rd(8'(a * 4), 32'h0, (a == 6) ? RESP_SLVERR : RESP_OKAY);
		end
		wr(8'h18, 32'h1, RESP_SLVERR);
		wr(OFS_MNEM, 32'h00544152, RESP_OKAY);
		wr(OFS_VALUE, 32'h00123456, RESP_OKAY);
		// Every rate, abbreviated transmit command
		for (int b = 0; b < 6; b++) begin
			bit_len <= 20'h00004 << (5 - b);
			wr(OFS_CTRL, 32'(b * 2), RESP_OKAY);
			wr(OFS_CMD, 32'h10, RESP_OKAY);
			build(1'b0, 7'h00, 25'h0123456, END_NONE);
			expect_line(10, 10);
		end
		// Full format, negative; blank then set address; single, middle and last block lines
		wr(OFS_CTRL, 32'h0B, RESP_OKAY);
		wr(OFS_VALUE, 32'h01000789, RESP_OKAY);
		wr(OFS_CMD, 32'h11, RESP_OKAY);
		build(1'b1, 7'h00, 25'h1000789, END_CR);
		expect_line(DLY - 2, 2 * DLY);
		wr(OFS_ADDR, 32'h2A, RESP_OKAY);
		wr(OFS_ADDR, 32'h64, RESP_OKAY);
		rd(OFS_ADDR, 32'h2A, RESP_OKAY);
		wr(OFS_CMD, 32'h12, RESP_OKAY);
		build(1'b1, 7'h2A, 25'h1000789, END_MID);
		expect_line(DLY - 2, 2 * DLY);
		panel <= 1'h1;
		wr(OFS_CMD, 32'h13, RESP_OKAY);
		build(1'b1, 7'h2A, 25'h1000789, END_BLK);
		expect_line(DLY - 2, PAN + 8);
		panel <= 1'h0;
		// Trigger while busy is dropped
		// Rate code 7 clamps to the top rate
		wr(OFS_CTRL, 32'h0E, RESP_OKAY);
		wr(OFS_CMD, 32'h10, RESP_OKAY);
		wr(OFS_CMD, 32'h11, RESP_OKAY);
		build(1'b0, 7'h00, 25'h1000789, END_NONE);
		expect_line(0, 0);
		rd(OFS_STAT, 32'h4, RESP_OKAY);
		wr(OFS_STAT, 32'h4, RESP_OKAY);
		rd(OFS_STAT, 32'h0, RESP_OKAY);
		// Loop current cut in mid-line holds output
		wr(OFS_CMD, 32'h10, RESP_OKAY);
		repeat (20) @(posedge aclk);
		hold <= 1'h1;
		repeat (300) @(posedge aclk);
		chk32(u_host.rx_q.size(), 32'h1);
		rd(OFS_STAT, 32'h3, RESP_OKAY);
		hold <= 1'h0;
		expect_line(9, 9);
		// Print inputs
		wr(OFS_CTRL, 32'h5A, RESP_OKAY);
		hold <= 1'h1;
		press(1'b0, 30);
		repeat (200) @(posedge aclk);
		chk32(u_host.rx_q.size(), 32'h0);
		hold <= 1'h0;
		press(1'b1, 30);
		repeat (200) @(posedge aclk);
		chk32(u_host.rx_q.size(), 32'h0);
		press(1'b0, 10);
		repeat (200) @(posedge aclk);
		chk32(u_host.rx_q.size(), 32'h0);
		press(1'b0, 30);
		build(1'b0, 7'h00, 25'h1000789, END_CR);
		expect_line(30, 30);
		chk32(u_host.frame_err, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
